/* File: hdl/pin_ctrl_defines.svh */
// Offsets, field positions, reset values and timing counts of the pin control block
`ifndef PIN_CTRL_DEFINES_SVH
`define PIN_CTRL_DEFINES_SVH

// Register index of the pin control register; byte address is four times it
`define PIN_CTRL_IDX 16'h4041
`define PIN_CTRL_ADDR 18'h10104
`define IRQ_STATUS_ADDR 18'h10108
`define IRQ_MASK_ADDR 18'h1010c
`define PIN_STATE_ADDR 18'h10110
`define ADDR_W 18

`define FLD_DIR 15
`define FLD_PULL_HI 14
`define FLD_PULL_LO 13
`define FLD_IRQ_MODE 12
`define FLD_SUPPLY 11
`define FLD_POL 10
`define FLD_OD 9
`define FLD_ENA 7
`define FLD_FN_HI 3
`define FLD_FN_LO 0
`define PIN_CTRL_RESET 16'ha400
`define PIN_CTRL_WMASK 16'hfe8f

`define PULL_NONE 2'h0
`define PULL_DOWN 2'h1
`define PULL_UP 2'h2

// Long de-bounce: 10 ms at 25 MHz, in whole cycles (least time, rounded up)
`define DEB_LONG_US 10000
`define SYS_CLK_MHZ 25
`define DEB_LONG_CYC ((`DEB_LONG_US * `SYS_CLK_MHZ))
`define DEB_CNT_W 18

`endif

/* File: hdl/pin_ctrl_pkg.sv */
// Types shared by the pin control block
package pin_ctrl_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } bus_phase_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        bus_phase_t phase;
        logic [17:0] addr;
        logic [31:0] rdata;
        logic level_prev;
        logic pin_out;
        logic pin_oe;
    } top_state_t;

    typedef struct packed {
        logic stable;
        logic [17:0] count;
    } deb_state_t;

endpackage

/* File: hdl/pin_debounce.sv */
// Long de-bounce filter for the pin input
`timescale 1ns/1ps
`default_nettype none
`include "pin_ctrl_defines.svh"

module pin_debounce #(
    parameter logic [17:0] LONG_CYC = 18'(`DEB_LONG_CYC)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic raw_level,
    output logic filt_level
);
    pin_ctrl_pkg::deb_state_t s_q;
    pin_ctrl_pkg::deb_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (raw_level == s_q.stable) begin
            s_d.count = '0;
        end else if (s_q.count >= LONG_CYC - 18'h1) begin
            s_d.stable = raw_level; // [RQ17]
            s_d.count = '0;
        end else begin
            s_d.count = s_q.count + 18'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign filt_level = s_q.stable;

    chk_filter_holds: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ17]
        (raw_level == s_q.stable) |=> $stable(s_q.stable))
        else $error("filtered level changed without a pending difference");
endmodule // pin_debounce
`default_nettype wire

/* File: hdl/pin_ctrl.sv */
// Control logic for one general-purpose pin with AHB-Lite registers
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pin_ctrl_defines.svh"

// How it works
// [RQ1] Bit 15 direction; bit 9 open drain
// [RQ2] Bits 14:13 choose pull resistor
// [RQ3] Mode 0: edge picked by polarity
// [RQ4] Mode 1: interrupt on both edges
// [RQ5] Bit 11 selects pad supply domain
// [RQ6] Bit 10 zero inverts the pin
// [RQ7] Bit 7 zero keeps pin tri-stated
// [RQ8] Input code 0 debounced, 1 raw
// [RQ9] Input codes 2-6 are power requests
// [RQ10] Code 7 watchdog, 8-9 voltage scaling
// [RQ11] Codes 10-15 hardware enable/control inputs
// [RQ12] Output codes 0-4: software, osc, states
// [RQ13] Output codes 5-7 reserved for software
// [RQ14] Output codes 8-9 scaling done flags
// [RQ15] Output codes 10-13 enables and supply flags
// [RQ16] Code 14 2MHz clock, 15 aux reset
// [RQ17] Direction picks table; fixed long filter
module pin_ctrl #(
    parameter logic [17:0] DEB_LONG_CYC = 18'(`DEB_LONG_CYC)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pull_up_en,
    output logic pull_down_en,
    output logic pad_supply_select,
    input wire logic sw_out_value,
    input wire logic osc_32k,
    input wire logic on_state,
    input wire logic sleep_state,
    input wire logic power_state_change,
    input wire logic dvs_done_one,
    input wire logic dvs_done_two,
    input wire logic ext_power_en_one,
    input wire logic ext_power_en_two,
    input wire logic system_supply_good,
    input wire logic converter_power_good,
    input wire logic ext_power_clk_2m,
    input wire logic aux_reset,
    output logic gpio_level,
    output logic on_off_req,
    output logic sleep_wake_req,
    output logic sleep_req,
    output logic power_on_req,
    output logic watchdog_reset_in,
    output logic voltage_scale_select_one,
    output logic voltage_scale_select_two,
    output logic hw_enable_one,
    output logic hw_enable_two,
    output logic hw_control_one,
    output logic hw_control_two,
    output logic irq
);
    // ------------------------------------------------------------
    // State and decode helpers
    // ------------------------------------------------------------
    pin_ctrl_pkg::top_state_t s_q;
    pin_ctrl_pkg::top_state_t s_d;
    logic [15:0] ctrl;
    logic [3:0] fn;
    logic is_input;
    logic in_raw;
    logic in_deb;
    logic in_active;
    logic in_level;
    logic rise;
    logic fall;
    logic edge_evt;
    logic mapped;
    logic [31:0] read_mux;
    logic out_src;
    logic out_active;
    logic [11:0] req_vec;

    // Long filter on debounced functions only
    function automatic logic uses_long(input logic [3:0] code);
        return code == 4'h0 || code == 4'h4 || code == 4'he || code == 4'hf;
    endfunction

    function automatic logic is_mapped(input logic [17:0] a);
        return a == `PIN_CTRL_ADDR || a == `IRQ_STATUS_ADDR
            || a == `IRQ_MASK_ADDR || a == `PIN_STATE_ADDR;
    endfunction

    assign ctrl = s_q.ctrl;
    assign fn = ctrl[`FLD_FN_HI:`FLD_FN_LO];
    assign is_input = ctrl[`FLD_DIR]; // [RQ17]

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    // Pad treated as synchronous to sys_clk; no resampling stage
    assign in_raw = pin_in ~^ ctrl[`FLD_POL]; // [RQ6]

    pin_debounce #(
        .LONG_CYC(DEB_LONG_CYC)
    ) u_deb (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .raw_level(in_raw),
        .filt_level(in_deb)
    );

    assign in_level = uses_long(fn) ? in_deb : in_raw; // [RQ8]
    assign in_active = ctrl[`FLD_ENA] && is_input && in_level;

    always_comb begin
        gpio_level = ctrl[`FLD_ENA] && is_input && fn <= 4'h1 && in_level; // [RQ8]
        on_off_req = in_active && fn == 4'h2; // [RQ9]
        sleep_wake_req = in_active && (fn == 4'h3 || fn == 4'h4); // [RQ9]
        sleep_req = in_active && fn == 4'h5; // [RQ9]
        power_on_req = in_active && fn == 4'h6; // [RQ9]
        watchdog_reset_in = in_active && fn == 4'h7; // [RQ10]
        voltage_scale_select_one = in_active && fn == 4'h8; // [RQ10]
        voltage_scale_select_two = in_active && fn == 4'h9; // [RQ10]
        hw_enable_one = in_active && fn == 4'ha; // [RQ11]
        hw_enable_two = in_active && fn == 4'hb; // [RQ11]
        hw_control_one = in_active && (fn == 4'hc || fn == 4'he); // [RQ11]
        hw_control_two = in_active && (fn == 4'hd || fn == 4'hf); // [RQ11]
    end

    assign req_vec = {gpio_level, hw_control_two, hw_control_one, hw_enable_two, hw_enable_one,
        voltage_scale_select_two, voltage_scale_select_one, watchdog_reset_in, power_on_req,
        sleep_req, sleep_wake_req, on_off_req};

    // Polarity is already in the level, so its rise is the active pin edge
    assign rise = in_level && !s_q.level_prev;
    assign fall = !in_level && s_q.level_prev;
    assign edge_evt = ctrl[`FLD_ENA] && is_input
        && (ctrl[`FLD_IRQ_MODE] ? (rise || fall) // [RQ4]
            : rise); // [RQ3]

    // ------------------------------------------------------------
    // Output path
    // ------------------------------------------------------------
    always_comb begin
        case (fn) // [RQ12]
            4'h0: out_src = sw_out_value;
            4'h1: out_src = osc_32k;
            4'h2: out_src = on_state;
            4'h3: out_src = sleep_state;
            4'h4: out_src = power_state_change;
            4'h8: out_src = dvs_done_one; // [RQ14]
            4'h9: out_src = dvs_done_two; // [RQ14]
            4'ha: out_src = ext_power_en_one; // [RQ15]
            4'hb: out_src = ext_power_en_two; // [RQ15]
            4'hc: out_src = system_supply_good; // [RQ15]
            4'hd: out_src = converter_power_good; // [RQ15]
            4'he: out_src = ext_power_clk_2m; // [RQ16]
            4'hf: out_src = aux_reset; // [RQ16]
            // Reserved codes drive a quiet inactive level
            default: out_src = 1'b0; // [RQ13]
        endcase
    end

    assign out_active = out_src ~^ ctrl[`FLD_POL]; // [RQ6]

    // ------------------------------------------------------------
    // Bus and state update
    // ------------------------------------------------------------
    assign mapped = is_mapped(haddr[`ADDR_W-1:0]) && haddr[31:`ADDR_W] == '0;

    always_comb begin
        read_mux = '0;
        case (haddr[`ADDR_W-1:0])
            `PIN_CTRL_ADDR: read_mux = {16'h0, ctrl};
            `IRQ_STATUS_ADDR: read_mux = {28'h0, s_q.irq_status};
            `IRQ_MASK_ADDR: read_mux = {28'h0, s_q.irq_mask};
            `PIN_STATE_ADDR: read_mux = {30'h0, pin_in, in_level};
            default: read_mux = '0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.level_prev = in_level;
        case (s_q.phase)
            pin_ctrl_pkg::BUS_WRITE: begin
                if (s_q.addr == `PIN_CTRL_ADDR) begin
                    s_d.ctrl = hwdata[15:0] & `PIN_CTRL_WMASK;
                end
                if (s_q.addr == `IRQ_MASK_ADDR) begin
                    s_d.irq_mask = hwdata[3:0];
                end
                if (s_q.addr == `IRQ_STATUS_ADDR) begin
                    s_d.irq_status = s_q.irq_status & ~hwdata[3:0];
                end
            end
            default: ;
        endcase
        // Set after clear: an edge in the clearing cycle survives
        if (edge_evt) begin
            s_d.irq_status[0] = 1'b1; // [RQ3]
        end
        s_d.phase = pin_ctrl_pkg::BUS_IDLE;
        s_d.rdata = '0;
        if (hsel && hready && htrans[1]) begin
            s_d.addr = haddr[`ADDR_W-1:0];
            if (!mapped) begin
                s_d.phase = pin_ctrl_pkg::BUS_IDLE;
            end else if (hwrite) begin
                s_d.phase = pin_ctrl_pkg::BUS_WRITE;
            end else begin
                s_d.phase = pin_ctrl_pkg::BUS_READ;
                s_d.rdata = read_mux;
            end
        end
        // Registered pad drive; tri-state unless enabled as an output
        s_d.pin_oe = 1'b0;
        s_d.pin_out = 1'b0;
        if (ctrl[`FLD_ENA] && !is_input) begin // [RQ7]
            if (ctrl[`FLD_OD]) begin // [RQ1]
                s_d.pin_oe = !out_active;
            end else begin
                s_d.pin_oe = 1'b1;
                s_d.pin_out = out_active;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{ctrl: `PIN_CTRL_RESET, phase: pin_ctrl_pkg::BUS_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign pin_out = s_q.pin_out;
    assign pin_oe = s_q.pin_oe;
    // Reserved pull code 11 drives neither resistor
    assign pull_down_en = ctrl[`FLD_ENA] && ctrl[14:13] == `PULL_DOWN; // [RQ2]
    assign pull_up_en = ctrl[`FLD_ENA] && ctrl[14:13] == `PULL_UP; // [RQ2]
    assign pad_supply_select = ctrl[`FLD_SUPPLY]; // [RQ5]
    assign irq = |(s_q.irq_status & s_q.irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_tristate_off: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ7]
        !ctrl[`FLD_ENA] |=> !pin_oe)
        else $error("pin driven while disabled");
    chk_input_no_drive: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ1]
        is_input |=> !pin_oe)
        else $error("input pin driven");
    chk_od_no_high: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ1]
        pin_oe && $past(ctrl[`FLD_OD]) |-> !pin_out)
        else $error("open drain drove high");
    chk_cmos_follows: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ12]
        ctrl[`FLD_ENA] && !is_input && !ctrl[`FLD_OD] && fn == 4'h0 && ctrl[`FLD_POL]
        && $stable(ctrl) |=> pin_oe && pin_out == $past(sw_out_value))
        else $error("software value not driven");
    chk_both_edges: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ4]
        ctrl[`FLD_ENA] && is_input && ctrl[`FLD_IRQ_MODE] && in_level != s_q.level_prev
        |=> s_q.irq_status[0])
        else $error("edge lost");
    chk_one_edge: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ3]
        !ctrl[`FLD_IRQ_MODE] && fall |-> !edge_evt)
        else $error("inactive edge raised interrupt");
    chk_active_edge: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ3]
        ctrl[`FLD_ENA] && is_input && !ctrl[`FLD_IRQ_MODE] && rise |=> s_q.irq_status[0])
        else $error("active edge lost");
    chk_pull_exclusive: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ2]
        !(pull_up_en && pull_down_en))
        else $error("both pull resistors on");
    chk_disabled_quiet: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ7]
        !ctrl[`FLD_ENA] |-> !pull_up_en && !pull_down_en && req_vec == 12'h0 && !edge_evt)
        else $error("disabled pin active");
    chk_output_no_req: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ17]
        !is_input |-> req_vec == 12'h0)
        else $error("request from output pin");
    chk_one_request: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ17]
        $onehot0(req_vec))
        else $error("several requests at once");
    chk_od_drives_low: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ1]
        ctrl[`FLD_ENA] && !is_input && ctrl[`FLD_OD] && !out_active
        |=> pin_oe && !pin_out)
        else $error("open drain not pulling low");
    chk_cmos_inverted: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ6]
        ctrl[`FLD_ENA] && !is_input && !ctrl[`FLD_OD] && !ctrl[`FLD_POL] && fn == 4'h0
        |=> pin_oe && pin_out == !$past(sw_out_value))
        else $error("inverted output wrong");
    chk_raw_code: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ8]
        ctrl[`FLD_ENA] && is_input && fn == 4'h1 |-> gpio_level == in_raw)
        else $error("unfiltered input not direct");
    chk_long_code: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ8]
        ctrl[`FLD_ENA] && is_input && fn == 4'h0 |-> gpio_level == in_deb)
        else $error("filtered input bypassed");
    chk_sleep_route: assert property (@(posedge sys_clk) disable iff (!nrst) // [RQ9]
        sleep_req |-> is_input && fn == 4'h5)
        else $error("sleep request on wrong code");
    chk_irq_level: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(s_q.irq_status[0] && s_q.irq_mask[0]) |-> !irq)
        else $error("interrupt without cause");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    chk_write_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_q.phase == pin_ctrl_pkg::BUS_WRITE && s_q.addr == `PIN_CTRL_ADDR
        |=> ctrl == ($past(hwdata[15:0]) & `PIN_CTRL_WMASK))
        else $error("control write not stored");
    chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_q.phase != pin_ctrl_pkg::BUS_READ |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (!nrst)
        hsel && hready && htrans[1] && !hwrite && !mapped |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_upper: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_q.irq_status[3:1] == 3'h0)
        else $error("unused status bit set");
    chk_masked_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
        ctrl[8] == 1'b0 && ctrl[6:4] == 3'h0)
        else $error("reserved control bit set");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    cov_edge_irq: cover property (@(posedge sys_clk) disable iff (!nrst) edge_evt ##1 irq);
    cov_od_drive: cover property (@(posedge sys_clk) disable iff (!nrst)
        pin_oe && ctrl[`FLD_OD]);
    cov_write_ctrl: cover property (@(posedge sys_clk) disable iff (!nrst)
        s_q.phase == pin_ctrl_pkg::BUS_WRITE && s_q.addr == `PIN_CTRL_ADDR);
    cov_filter_flip: cover property (@(posedge sys_clk) disable iff (!nrst)
        $changed(in_deb));
    cov_both_edges: cover property (@(posedge sys_clk) disable iff (!nrst)
        ctrl[`FLD_IRQ_MODE] && fall && edge_evt);
endmodule // pin_ctrl
`default_nettype wire

/* File: tb/pin_board.sv */
// Board-level model of the logic hanging on the pin
`timescale 1ns/1ps
`default_nettype none

module pin_board (
    input wire logic sys_clk,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic ext_en,
    input wire logic ext_level,
    output logic pin_level
);
    logic float_q = 1'b0;

    // Unpulled, undriven pad toggles so a stale level never reads as valid
    always_ff @(posedge sys_clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        if (pin_oe) begin
            pin_level = pin_out;
        end else if (ext_en) begin
            pin_level = ext_level;
        end else if (pull_up_en) begin
            pin_level = 1'b1;
        end else if (pull_down_en) begin
            pin_level = 1'b0;
        end else begin
            pin_level = float_q;
        end
    end
endmodule // pin_board

`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
`include "pin_ctrl_defines.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: %s", $time, m); end end

module tb_top;
    localparam int DEB = 8;
    localparam logic [31:0] CTRL = 32'(`PIN_CTRL_ADDR);
    localparam logic [31:0] STAT = 32'(`IRQ_STATUS_ADDR);
    localparam logic [31:0] MASK = 32'(`IRQ_MASK_ADDR);
    localparam logic [31:0] STATE = 32'(`PIN_STATE_ADDR);
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, pad_supply;
    logic [15:0] src = 16'h0;
    logic ext_en = 1'b1;
    logic ext_level = 1'b0;
    logic [11:0] reqv;
    logic irq;
    logic [31:0] dummy;
    int fail_count = 0;
    int checked = 0;

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Design and board
    // ----------------------------------------
    pin_ctrl #(.DEB_LONG_CYC(18'(DEB))) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .pad_supply_select(pad_supply),
        .sw_out_value(src[0]), .osc_32k(src[1]), .on_state(src[2]), .sleep_state(src[3]),
        .power_state_change(src[4]), .dvs_done_one(src[8]), .dvs_done_two(src[9]),
        .ext_power_en_one(src[10]), .ext_power_en_two(src[11]),
        .system_supply_good(src[12]), .converter_power_good(src[13]),
        .ext_power_clk_2m(src[14]), .aux_reset(src[15]), .gpio_level(reqv[11]),
        .on_off_req(reqv[0]), .sleep_wake_req(reqv[1]), .sleep_req(reqv[2]),
        .power_on_req(reqv[3]), .watchdog_reset_in(reqv[4]),
        .voltage_scale_select_one(reqv[5]), .voltage_scale_select_two(reqv[6]),
        .hw_enable_one(reqv[7]), .hw_enable_two(reqv[8]), .hw_control_one(reqv[9]),
        .hw_control_two(reqv[10]), .irq(irq));

    pin_board i_board (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
        .ext_level(ext_level), .pin_level(pin_in));

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                fail_count++;
                $display("wrong value at %0t: bus hung", $time);
                test_done();
            end
            @(posedge sys_clk);
        end
    endtask

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rdv);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, dummy);
        // One idle edge so outputs fed by the stored value have settled
        @(posedge sys_clk);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string m);
        logic [31:0] v;
        bus(a, 1'b0, 32'h0, v);
        `CHK(v, e, m)
    endtask

    function automatic logic [11:0] exp_req(input logic [3:0] c);
        case (c)
            4'h0, 4'h1: return 12'h800;
            4'h2: return 12'h001;
            4'h3, 4'h4: return 12'h002;
            4'hc, 4'he: return 12'h200;
            4'hd, 4'hf: return 12'h400;
            default: return 12'h1 << (c - 4'h3);
        endcase
    endfunction

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rdchk(CTRL, 32'h0000a400, "ctrl reset");
        `CHK({pin_oe, pull_up_en, pull_down_en}, 3'b000, "tri-state at reset")
        wr(CTRL, 32'hffffdfff);
        rdchk(CTRL, 32'h0000de8f, "ctrl write mask");
        rdchk(32'h00010200, 32'h0, "unmapped read");
        ext_level <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            wr(CTRL, 32'h8081 | (p << 13));
            `CHK({pull_up_en, pull_down_en}, 2'(p), "pull select")
        end
        wr(CTRL, 32'h8881);
        `CHK(pad_supply, 1'b1, "supply select")
        for (int c = 0; c < 16; c++) begin
            wr(CTRL, 32'h8480 | c);
            // Long-filtered codes need the whole filter time
            repeat (DEB + 2) @(posedge sys_clk);
            `CHK(reqv, exp_req(4'(c)), "input function")
        end
        rdchk(STATE, 32'h3, "pin state");
        wr(CTRL, 32'h8480);
        ext_level <= 1'b0;
        repeat (DEB) @(posedge sys_clk);
        `CHK(reqv[11], 1'b1, "filtered too soon")
        repeat (2) @(posedge sys_clk);
        `CHK(reqv[11], 1'b0, "filtered level")
        wr(CTRL, 32'h8081);
        repeat (2) @(posedge sys_clk);
        `CHK(reqv[11], 1'b1, "inverted input")
        wr(MASK, 32'h1);
        wr(CTRL, 32'h8481);
        repeat (3) @(posedge sys_clk);
        wr(STAT, 32'h1);
        ext_level <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdchk(STAT, 32'h1, "rising edge");
        `CHK(irq, 1'b1, "irq raised")
        wr(STAT, 32'h1);
        ext_level <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rdchk(STAT, 32'h0, "falling ignored");
        `CHK(irq, 1'b0, "irq cleared")
        wr(CTRL, 32'h8081);
        wr(STAT, 32'h1);
        ext_level <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdchk(STAT, 32'h0, "inverted rise ignored");
        ext_level <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rdchk(STAT, 32'h1, "inverted fall");
        wr(CTRL, 32'h9481);
        ext_level <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wr(STAT, 32'h1);
        ext_level <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rdchk(STAT, 32'h1, "both edges");
        wr(MASK, 32'h0);
        `CHK(irq, 1'b0, "irq masked")
        ext_en <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            if (c inside {[5:7]}) continue;
            wr(CTRL, 32'h0480 | c);
            src <= 16'h0;
            repeat (2) @(posedge sys_clk);
            `CHK({pin_oe, pin_out}, 2'b10, "output idle")
            src <= 16'h1 << c;
            repeat (2) @(posedge sys_clk);
            `CHK({pin_oe, pin_out}, 2'b11, "output source")
        end
        wr(CTRL, 32'h0080);
        src <= 16'h1;
        repeat (2) @(posedge sys_clk);
        `CHK(pin_out, 1'b0, "inverted output")
        wr(CTRL, 32'h0680);
        repeat (2) @(posedge sys_clk);
        `CHK(pin_oe, 1'b0, "open drain released")
        src <= 16'h0;
        repeat (2) @(posedge sys_clk);
        `CHK({pin_oe, pin_out}, 2'b10, "open drain low")
        wr(CTRL, 32'h0400);
        repeat (2) @(posedge sys_clk);
        `CHK(pin_oe, 1'b0, "disabled pin")
        test_done();
    end
endmodule // tb_top

`default_nettype wire
